/* design/pbl_consts.svh */
// Purpose: constants of the programmable port bit logic
// Assumes: one 8-bit port, register select from the core register file
// Notes: mode codes are {config_bit_two, config_bit_one, config_bit_zero}
// Overview of operation
// - Decode three config bits per pin into bidirectional, output, input or alternate modes.
// - CMOS threshold only for code 001; other codes TTL unless Schmitt fitted.
// - On converter pins code 111 selects analog input, driver off.
// - Output mode drives push-pull or open-drain; instruction end copies master to both latches.
// - Bidirectional drives open-drain or weak pull-up; samples pin at instruction start.
// - Reads return pin levels for bidirectional bits, so read-modify-write sees pins.
// - Alternate output lets the peripheral load the slave latch; pin still sampled.
// - With no peripheral connected, push-pull drives high, open-drain floats.
// - Pin input feeds the alternate input of every pin not in alternate output; parallel reads keep working.
// - Converter pin in alternate open-drain forces alternate output to one.
// - Several peripheral outputs on one pin are ANDed before driving.
// - A pin with alternate output shows that driven output on its alternate input.
// - In wait-for-interrupt the instruction strobes are ignored; master still takes port writes.
// - In halt the instruction strobes are ignored; master still takes port writes.
// - Port write loads master latches; port read returns the input latch.
// - Input mode floats driver, samples pin at start, still copies master to slave.
// - Reset gives bidirectional weak pull-up except on WPU_DISABLED pins, and data all ones, held afterwards.
`ifndef PBL_CONSTS_SVH
`define PBL_CONSTS_SVH
`define PBL_SEL_DATA 2'h0
`define PBL_SEL_CFG0 2'h1
`define PBL_SEL_CFG1 2'h2
`define PBL_SEL_CFG2 2'h3
`define PBL_DATA_RST 8'hff
`define PBL_CFG_RST 8'h00
`define PBL_CODE_CMOS 3'h1
`endif

/* design/pbl_pkg.sv */
// Purpose: types of the programmable port bit logic
// Assumes: nothing
// Notes: mode of one pin after decoding
package pbl_pkg;
  typedef enum logic [1:0] {PBL_TWO_WAY, PBL_OUT, PBL_IN, PBL_PERIPH} pbl_mode_type;
endpackage

/* design/pbl_port.sv */
// Purpose: 8-bit programmable port, latches, drivers and alternate function sharing
// Assumes: core gives one-cycle strobes at instruction start and end
// Notes: pad electrics are outside; oe high means the pad driver is on
`timescale 1ns/1ps
`default_nettype none
`include "pbl_consts.svh"
module pbl_port
  import pbl_pkg::*;
#(
  parameter logic [7:0] ADC_PINS = 8'h00,
  parameter logic [7:0] SCHMITT_PINS = 8'h00,
  parameter logic [7:0] WPU_DISABLED = 8'h00
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // register file access
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [1:0] i_reg_sel,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // core timing and power modes
  input wire logic i_instr_start,
  input wire logic i_instr_end,
  input wire logic i_wait_for_interrupt_state,
  input wire logic i_halt,
  // peripherals, two output sources per pin
  input wire logic [7:0] i_af0_out,
  input wire logic [7:0] i_af0_en,
  input wire logic [7:0] i_af1_out,
  input wire logic [7:0] i_af1_en,
  output logic [7:0] o_analog_sense_setting,
  // pads
  input wire logic [7:0] i_pin,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe,
  output logic [7:0] o_pull_up,
  output logic [7:0] o_cmos_thr,
  output logic [7:0] o_analog_sel
);

  logic [7:0] cfg0, cfg1, cfg2, master, slave, in_latch, pin_meta, pin_s;
  logic [7:0] next_cfg0, next_cfg1, next_cfg2, next_master, next_slave, next_in_latch;
  logic [7:0] next_rdata, next_out, next_oe, next_pull, next_cmos, next_analog, next_analog_sense_setting;
  // per-pin mode decode and masks
  logic [7:0] outm, inm, afm, ppm, adcm, af_val;
  logic ev_start, ev_end;
  pbl_mode_type mode [8];

  // input and slave latches ignore the instruction strobes while the core waits or halts
  assign ev_start = i_instr_start & ~i_wait_for_interrupt_state & ~i_halt;
  assign ev_end = i_instr_end & ~i_wait_for_interrupt_state & ~i_halt;
  // shared peripheral outputs, disabled or absent sources read as one
  assign af_val = (i_af0_out | ~i_af0_en) & (i_af1_out | ~i_af1_en);

  always_comb begin
    for (int n = 0; n < 8; n++) begin
      // config_bit_two picks buffer type, threshold and converter analog, not the mode
      unique case ({cfg1[n], cfg0[n]})
        2'h0: mode[n] = PBL_TWO_WAY;
        2'h1: mode[n] = PBL_IN;
        2'h2: mode[n] = PBL_OUT;
        2'h3: mode[n] = PBL_PERIPH;
      endcase
      outm[n] = (mode[n] == PBL_OUT);
      inm[n] = (mode[n] == PBL_IN);
      adcm[n] = ADC_PINS[n] & cfg2[n] & cfg1[n] & cfg0[n];
      afm[n] = (mode[n] == PBL_PERIPH) & ~adcm[n];
      ppm[n] = ~cfg2[n] & cfg1[n];
    end
  end

  always_comb begin
    next_cfg0 = cfg0;
    next_cfg1 = cfg1;
    next_cfg2 = cfg2;
    next_master = master;
    // read and write in one cycle: the read returns the old value
    if (i_reg_wr) begin
      unique case (i_reg_sel)
        `PBL_SEL_DATA: next_master = i_reg_wdata;
        `PBL_SEL_CFG0: next_cfg0 = i_reg_wdata;
        `PBL_SEL_CFG1: next_cfg1 = i_reg_wdata;
        `PBL_SEL_CFG2: next_cfg2 = i_reg_wdata;
      endcase
    end
    next_rdata = o_reg_rdata;
    if (i_reg_rd) begin
      unique case (i_reg_sel)
        `PBL_SEL_DATA: next_rdata = in_latch;
        `PBL_SEL_CFG0: next_rdata = cfg0;
        `PBL_SEL_CFG1: next_rdata = cfg1;
        `PBL_SEL_CFG2: next_rdata = cfg2;
      endcase
    end
    next_in_latch = in_latch;
    next_slave = slave;
    // end after start: output pins take master when both strobes coincide
    for (int n = 0; n < 8; n++) begin
      if (ev_start && !outm[n]) begin
        next_in_latch[n] = pin_s[n];
      end
      if (ev_end && outm[n]) begin
        next_in_latch[n] = master[n];
      end
      // converter pins in code 111 ignore peripherals and hold the slave high
      if (adcm[n]) begin
        next_slave[n] = 1'b1;
      end else if (afm[n]) begin
        // peripheral timing: slave follows the combined value every clock
        next_slave[n] = af_val[n];
      end else if (ev_end) begin
        next_slave[n] = master[n];
      end
    end
  end

  // pad controls from the latch state, all registered
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      next_out[n] = slave[n];
      next_oe[n] = 1'b0;
      next_pull[n] = 1'b0;
      // open-drain and bidirectional pins drive only a low level
      if (!inm[n] && !adcm[n]) begin
        next_oe[n] = ppm[n] | ~slave[n];
      end
      if (mode[n] == PBL_TWO_WAY && !cfg2[n] && !WPU_DISABLED[n]) begin
        next_pull[n] = slave[n];
      end
      next_cmos[n] = ({cfg2[n], cfg1[n], cfg0[n]} == `PBL_CODE_CMOS) & ~SCHMITT_PINS[n];
      next_analog[n] = adcm[n];
      next_analog_sense_setting[n] = afm[n] ? af_val[n] : pin_s[n];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_meta <= 8'h00;
      pin_s <= 8'h00;
      cfg0 <= `PBL_CFG_RST;
      cfg1 <= `PBL_CFG_RST;
      cfg2 <= `PBL_CFG_RST;
      master <= `PBL_DATA_RST;
      slave <= `PBL_DATA_RST;
      in_latch <= `PBL_DATA_RST;
      o_reg_rdata <= 8'h00;
      o_pin_out <= `PBL_DATA_RST;
      o_pin_oe <= 8'h00;
      o_pull_up <= ~WPU_DISABLED;
      o_cmos_thr <= 8'h00;
      o_analog_sel <= 8'h00;
      o_analog_sense_setting <= 8'h00;
    end else begin
      // two-flop synchroniser, pads are asynchronous to the core clock
      pin_meta <= i_pin;
      pin_s <= pin_meta;
      cfg0 <= next_cfg0;
      cfg1 <= next_cfg1;
      cfg2 <= next_cfg2;
      master <= next_master;
      slave <= next_slave;
      in_latch <= next_in_latch;
      o_reg_rdata <= next_rdata;
      o_pin_out <= next_out;
      o_pin_oe <= next_oe;
      o_pull_up <= next_pull;
      o_cmos_thr <= next_cmos;
      o_analog_sel <= next_analog;
      o_analog_sense_setting <= next_analog_sense_setting;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_write_master: assert property (
    i_reg_wr && i_reg_sel == `PBL_SEL_DATA |=> master == $past(i_reg_wdata))
    else $error("port write did not load master");
  a_read_input: assert property (
    i_reg_rd && i_reg_sel == `PBL_SEL_DATA |=> o_reg_rdata == $past(in_latch))
    else $error("port read not from input latch");
  a_end_copy: assert property (
    ev_end |=> ((in_latch ^ $past(master)) & $past(outm)) == 8'h00)
    else $error("output mode input latch not copied");
  a_start_sample: assert property (
    ev_start && !ev_end |=> ((in_latch ^ $past(pin_s)) & $past(~outm)) == 8'h00)
    else $error("pin not sampled at instruction start");
  a_slave_copy: assert property (
    ev_end |=> ((slave ^ $past(master)) & $past(~afm & ~adcm)) == 8'h00)
    else $error("slave latch not copied at instruction end");
  a_input_float: assert property (
    1 |=> (o_pin_oe & $past(inm)) == 8'h00 && (o_pull_up & $past(inm)) == 8'h00)
    else $error("input pin driven");
  a_pp_drive: assert property (
    1 |=> (~o_pin_oe & $past(ppm & ~inm & ~adcm)) == 8'h00)
    else $error("push-pull pin not driven");
  a_adc_analog: assert property (
    1 |=> o_analog_sel == $past(adcm) && (o_pin_oe & $past(adcm)) == 8'h00)
    else $error("converter pin not analog");
  a_af_and: assert property (
    1 |=> ((slave ^ $past(af_val)) & $past(afm)) == 8'h00)
    else $error("peripheral outputs not ANDed");
  a_af_loop: assert property (
    1 |=> ((o_analog_sense_setting ^ $past(af_val)) & $past(afm)) == 8'h00)
    else $error("alternate input lacks own output");
  a_halt_hold: assert property (
    i_halt && !i_reg_wr |=> $stable(in_latch) && $stable(master))
    else $error("port state changed in halt");
  a_wait_hold: assert property (
    i_wait_for_interrupt_state |=> $stable(in_latch))
    else $error("input latch changed in wait");

  c_two_way_rmw: cover property (ev_start && i_reg_wr && mode[0] == PBL_TWO_WAY);
  c_wait_block: cover property (i_wait_for_interrupt_state && i_instr_end);
  c_out_switch: cover property (inm[0] ##[1:20] outm[0]);
  c_af_drive: cover property (afm[0] && i_af0_en[0] && i_af1_en[0]);
  c_adc_pin: cover property (adcm != 8'h00);

endmodule
`default_nettype wire

/* test/pbl_pads_model.sv */
// Purpose: pad level model for the port pins
// Assumes: oe high puts o_pin_out on the pin
// Notes: an unpulled floating pin reads inverted to expose stale reads
`timescale 1ns/1ps
`default_nettype none
module pbl_pads_model (
  // pad side of the port
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_pull_up,
  // external forcing
  input wire logic [7:0] i_ext_en,
  input wire logic [7:0] i_ext_val,
  // resolved level
  output logic [7:0] o_pin
);
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (i_oe[n])
        o_pin[n] = i_out[n];
      else if (i_ext_en[n])
        o_pin[n] = i_ext_val[n];
      else
        o_pin[n] = i_pull_up[n] | ~i_out[n];
    end
  end
endmodule
`default_nettype wire

/* test/test_pbl_port.sv */
// Purpose: self-checking bench of the port bit logic
// Assumes: pbl_pads_model stands for the pins
// Notes: bit 7 is a converter pin, bit 6 lacks a weak pull-up, bit 0 is a Schmitt input
`timescale 1ns/1ps
`default_nettype none
module test_pbl_port;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_instr_start = 1'b0, i_instr_end = 1'b0;
  logic i_wait_for_interrupt_state = 1'b0, i_halt = 1'b0;
  logic [1:0] i_reg_sel = 2'h0;
  logic [7:0] i_reg_wdata = 8'h00, i_af0_out = 8'h00, i_af0_en = 8'h00, i_af1_out = 8'h00;
  logic [7:0] i_af1_en = 8'h00, ext_en = 8'h00, ext_val = 8'h00, v, pin;
  logic [7:0] o_reg_rdata, o_analog_sense_setting, o_pin_out, o_pin_oe, o_pull_up, o_cmos_thr, o_analog_sel;
  int mismatches = 0;
  int n_compared = 0;
  always #5 i_clk = ~i_clk;
  pbl_port #(.ADC_PINS(8'h80), .SCHMITT_PINS(8'h01), .WPU_DISABLED(8'h40)) i_pbl_port (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_sel(i_reg_sel), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_instr_start(i_instr_start), .i_instr_end(i_instr_end), .i_halt(i_halt),
    .i_wait_for_interrupt_state(i_wait_for_interrupt_state),
    .i_af0_out(i_af0_out), .i_af0_en(i_af0_en), .i_af1_out(i_af1_out), .i_af1_en(i_af1_en),
    .o_analog_sense_setting(o_analog_sense_setting), .i_pin(pin), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
    .o_pull_up(o_pull_up), .o_cmos_thr(o_cmos_thr), .o_analog_sel(o_analog_sel));
  pbl_pads_model i_pbl_pads_model (.i_out(o_pin_out), .i_oe(o_pin_oe), .i_pull_up(o_pull_up),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pin));
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_sel <= s;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] s);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_sel <= s;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 v = o_reg_rdata;
  endtask
  task automatic cfg(input logic [7:0] c2, input logic [7:0] c1, input logic [7:0] c0);
    wr(2'h3, c2);
    wr(2'h2, c1);
    wr(2'h1, c0);
    settle();
  endtask
  task automatic settle;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task automatic strobe(input logic s, input logic e);
    @(posedge i_clk);
    i_instr_start <= s;
    i_instr_end <= e;
    @(posedge i_clk);
    i_instr_start <= 1'b0;
    i_instr_end <= 1'b0;
    settle();
  endtask
  task automatic t_reset;
    settle();
    chk("out", o_pin_out, 8'hff);
    chk("oe", o_pin_oe, 8'h00);
    chk("pull", o_pull_up, 8'hbf);
    rd(2'h0);
    chk("data", v, 8'hff);
    rd(2'h1);
    chk("cfg0", v, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_output;
    cfg(8'h00, 8'hff, 8'h00);
    wr(2'h0, 8'h5a);
    strobe(1'b0, 1'b1);
    chk("out", o_pin_out, 8'h5a);
    chk("oe", o_pin_oe, 8'hff);
    rd(2'h0);
    chk("data", v, 8'h5a);
    @(posedge i_clk);
    i_wait_for_interrupt_state <= 1'b1;
    wr(2'h0, 8'ha5);
    strobe(1'b1, 1'b1);
    chk("wait", o_pin_out, 8'h5a);
    @(posedge i_clk);
    i_wait_for_interrupt_state <= 1'b0;
    i_halt <= 1'b1;
    strobe(1'b0, 1'b1);
    chk("halt", o_pin_out, 8'h5a);
    @(posedge i_clk);
    i_halt <= 1'b0;
    strobe(1'b0, 1'b1);
    chk("out", o_pin_out, 8'ha5);
    cfg(8'hff, 8'hff, 8'h00);
    chk("open drain oe", o_pin_oe, 8'h5a);
    $display("output test done");
  endtask
  task automatic t_two_way;
    cfg(8'h00, 8'h00, 8'h00);
    wr(2'h0, 8'h0f);
    strobe(1'b0, 1'b1);
    @(posedge i_clk);
    ext_en <= 8'h0c;
    settle();
    strobe(1'b1, 1'b0);
    rd(2'h0);
    chk("rmw", v, 8'h03);
    chk("pull", o_pull_up, 8'h0f);
    chk("thr", o_cmos_thr, 8'h00);
    // software sets bit 7 on its own copy 0f, then loads the port plainly
    wr(2'h0, 8'h8f);
    strobe(1'b0, 1'b1);
    chk("copy", o_pin_out, 8'h8f);
    $display("bidirectional test done");
  endtask
  task automatic t_input;
    cfg(8'h00, 8'h00, 8'hff);
    ext_en <= 8'hff;
    ext_val <= 8'hc3;
    wr(2'h0, 8'h3c);
    settle();
    strobe(1'b1, 1'b1);
    chk("oe", o_pin_oe, 8'h00);
    chk("thr", o_cmos_thr, 8'hfe);
    chk("pin afin", o_analog_sense_setting, 8'hc3);
    rd(2'h0);
    chk("data", v, 8'hc3);
    ext_en <= 8'h00;
    // via bidirectional, not alternate output, so the slave keeps its value
    wr(2'h1, 8'h00);
    wr(2'h2, 8'hff);
    settle();
    chk("out", o_pin_out, 8'h3c);
    $display("input test done");
  endtask
  task automatic t_af;
    cfg(8'h00, 8'hff, 8'hff);
    @(posedge i_clk);
    i_af0_out <= 8'hf0;
    i_af0_en <= 8'hff;
    i_af1_out <= 8'h3c;
    i_af1_en <= 8'hff;
    settle();
    chk("and", o_pin_out, 8'h30);
    chk("afin", o_analog_sense_setting, 8'h30);
    strobe(1'b1, 1'b0);
    rd(2'h0);
    chk("data", v, 8'h30);
    @(posedge i_clk);
    i_af0_en <= 8'h00;
    i_af1_en <= 8'h00;
    settle();
    chk("none", o_pin_out, 8'hff);
    cfg(8'hff, 8'hff, 8'hff);
    chk("open drain", o_pin_oe, 8'h00);
    @(posedge i_clk);
    i_af0_out <= 8'h00;
    i_af0_en <= 8'hff;
    settle();
    chk("adc out", o_pin_out, 8'h80);
    chk("adc oe", o_pin_oe, 8'h7f);
    chk("analog", o_analog_sel, 8'h80);
    $display("alternate test done");
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_reset();
    t_output();
    t_two_way();
    t_input();
    t_af();
    test_done();
  end
endmodule
`default_nettype wire
